/* bit_sync.sv */
// Two-stage synchroniser for asynchronous pin inputs
module bit_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_d,
    output logic [WIDTH-1:0] o_q
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta_reg <= '0;
            o_q <= '0;
        end else begin
            meta_reg <= i_d;
            o_q <= meta_reg;
        end
    end
endmodule : bit_sync

/* byte_fifo.sv */
// Byte FIFO between the serial receiver and the array write engine
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic i_clk,
    input wire logic i_rst,
    fifo_link_if.fifo link
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW:0] wr_ptr_reg;
    logic [PW:0] rd_ptr_reg;
    logic full;
    logic empty;
    logic do_push;
    logic do_pop;

    assign empty = (wr_ptr_reg == rd_ptr_reg);
    assign full = ((wr_ptr_reg ^ rd_ptr_reg) == {1'b1, {PW{1'b0}}});
    assign link.push_ready = !full;
    assign link.pop_valid = !empty;
    assign link.pop_data = store[rd_ptr_reg[PW-1:0]];
    assign do_push = link.push_valid && !full;
    assign do_pop = link.pop_ready && !empty;

    always_ff @(posedge i_clk) begin
        if (i_rst || link.flush) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (do_push) begin
            store[wr_ptr_reg[PW-1:0]] <= link.push_data;
        end
    end
endmodule : byte_fifo

/* eeprom_spi_pkg.sv */
// Shared constants and state type for the SPI EEPROM serial front end
// Contract
// - Data input sampled on serial clock rise
// - Data output changes only after clock fall
// - Deselected means data output floats
// - Deselected and idle means standby power
// - Nothing accepted before first select falling edge
// - Hold pauses transfer, keeps selection and position
// - In hold: output floats, clock/data ignored
// - Hold enters/leaves on hold edge, clock low
// - Deselect during hold resets the interface
// - Write protect low freezes block protect bits
// - All input bytes arrive MSB first
// - First bit on first rise after select
// - Read bytes MSB first from first fall
// - Works in clock modes 0 and 3
// - Byte array of 2048 or 1024 locations
// - Unknown opcode deselects until next select
package eeprom_spi_pkg;
    localparam int MEM_DEPTH_DEF = 2048;
    localparam int FIFO_DEPTH_DEF = 8;
    localparam int BYTE_W = 8;
    localparam int ADDR_BYTES = 2;
    localparam int BUS_AW = 16;
    localparam int PAGE_BITS = 5;
    localparam int SYNC_W = 5;
    localparam logic [7:0] OP_WR_STATUS = 8'h01;
    localparam logic [7:0] OP_WRITE = 8'h02;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_WR_DISABLE = 8'h04;
    localparam logic [7:0] OP_RD_STATUS = 8'h05;
    localparam logic [7:0] OP_WR_ENABLE = 8'h06;
    localparam int ST_BUSY = 0;
    localparam int ST_WEL = 1;
    localparam int ST_BP_LO = 2;
    localparam int ST_BP_HI = 3;
    localparam logic [1:0] BP_RST = 2'h0;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [1:0] CNT_MAX = 2'h3;

    typedef enum logic [2:0] {
        XS_IDLE = 3'h0,
        XS_OPCODE = 3'h1,
        XS_ADDR = 3'h3,
        XS_DATA_IN = 3'h2,
        XS_DATA_OUT = 3'h6
    } xfer_state_t;
endpackage : eeprom_spi_pkg

/* eeprom_spi_slave_frontend.sv */
// Serial front end and byte engine of the SPI EEPROM
module eeprom_spi_slave_frontend #(
    parameter int MEM_DEPTH = eeprom_spi_pkg::MEM_DEPTH_DEF,
    parameter int FIFO_DEPTH = eeprom_spi_pkg::FIFO_DEPTH_DEF
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_sclk,
    input wire logic i_sdi,
    input wire logic i_cs_n,
    input wire logic i_hold_n,
    input wire logic i_wp_n,
    output logic o_sdo,
    output logic o_sdo_oe,
    output logic o_standby
);
    import eeprom_spi_pkg::*;

    localparam int AW = $clog2(MEM_DEPTH);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [SYNC_W-1:0] pins_s;
    logic sclk_s;
    logic sdi_s;
    logic cs_n_s;
    logic hold_n_s;
    logic wp_n_s;
    logic sclk_prev_reg;
    logic cs_prev_reg;
    logic hold_prev_reg;
    logic cs_fall;
    logic cs_rise;
    logic hold_fall;
    logic hold_rise;
    logic active;
    logic sck_rise;
    logic sck_fall;
    logic byte_done;
    logic op_ok;
    logic sel_reg;
    logic hold_reg;
    xfer_state_t state_reg;
    logic [2:0] bit_cnt_reg;
    logic [1:0] in_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] rx_byte;
    logic [7:0] cmd_reg;
    logic [BUS_AW-1:0] addr_reg;
    logic [BUS_AW-1:0] first_addr;
    logic [BUS_AW-1:0] next_addr;
    logic wel_reg;
    logic wip_reg;
    logic [1:0] bp_reg;
    logic [7:0] status_byte;
    logic commit;
    logic do_wren;
    logic do_wrdi;
    logic do_wrsr;
    logic do_write;
    logic load_first;
    logic [7:0] out_sh_reg;
    logic [2:0] out_cnt_reg;
    logic out_started_reg;
    logic q_reg;
    logic oe_reg;
    logic standby_reg;
    logic [7:0] mem [MEM_DEPTH];

    fifo_link_if #(.WIDTH(BYTE_W)) u_link ();

    ////////////////////////////////////////////////////////////////////////
    // Functions

    function automatic logic valid_op(input logic [7:0] op);
        case (op)
            OP_WR_STATUS, OP_WRITE, OP_READ,
            OP_WR_DISABLE, OP_RD_STATUS, OP_WR_ENABLE: valid_op = 1'b1;
            default: valid_op = 1'b0;
        endcase
    endfunction : valid_op

    // Upper quarter, upper half or whole array
    function automatic logic is_protected(input logic [AW-1:0] a,
                                          input logic [1:0] bp);
        case (bp)
            2'h1: is_protected = &a[AW-1:AW-2];
            2'h2: is_protected = a[AW-1];
            2'h3: is_protected = 1'b1;
            default: is_protected = 1'b0;
        endcase
    endfunction : is_protected

    ////////////////////////////////////////////////////////////////////////
    // Pin sampling and edge detection

    bit_sync #(.WIDTH(SYNC_W)) u_sync (
        .i_clk(i_clk_sys),
        .i_rst(i_rst),
        .i_d({i_sclk, i_sdi, i_cs_n, i_hold_n, i_wp_n}),
        .o_q(pins_s)
    );

    assign sclk_s = pins_s[4];
    assign sdi_s = pins_s[3];
    assign cs_n_s = pins_s[2];
    assign hold_n_s = pins_s[1];
    assign wp_n_s = pins_s[0];

    // Select history resets low: a pin already low at release is no edge
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            sclk_prev_reg <= 1'b0;
            cs_prev_reg <= 1'b0;
            hold_prev_reg <= 1'b0;
        end else begin
            sclk_prev_reg <= sclk_s;
            cs_prev_reg <= cs_n_s;
            hold_prev_reg <= hold_n_s;
        end
    end

    assign cs_fall = cs_prev_reg & ~cs_n_s;
    assign cs_rise = ~cs_prev_reg & cs_n_s;
    assign hold_fall = hold_prev_reg & ~hold_n_s;
    assign hold_rise = ~hold_prev_reg & hold_n_s;
    assign active = sel_reg & ~hold_reg & ~cs_n_s;
    // Same edges in both clock modes; idle level never matters
    assign sck_rise = active & sclk_s & ~sclk_prev_reg;
    assign sck_fall = active & ~sclk_s & sclk_prev_reg;
    assign byte_done = sck_rise && (bit_cnt_reg == BIT_LAST);
    assign rx_byte = {shift_reg[6:0], sdi_s};
    // Only status reads are allowed while the array is busy
    assign op_ok = valid_op(rx_byte) && (!wip_reg || rx_byte == OP_RD_STATUS);

    ////////////////////////////////////////////////////////////////////////
    // Selection and hold

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            sel_reg <= 1'b0;
            hold_reg <= 1'b0;
        end else if (cs_rise) begin
            sel_reg <= 1'b0;
            hold_reg <= 1'b0;
        end else begin
            if (cs_fall) begin
                sel_reg <= 1'b1;
            end else if (byte_done && state_reg == XS_OPCODE && !op_ok) begin
                sel_reg <= 1'b0;
            end
            if (sel_reg && !cs_n_s && hold_fall && !sclk_s) begin
                hold_reg <= 1'b1;
            end else if (hold_reg && hold_rise && !sclk_s) begin
                hold_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive shifter and transfer state

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state_reg <= XS_IDLE;
            bit_cnt_reg <= 3'h0;
            in_cnt_reg <= 2'h0;
            shift_reg <= 8'h00;
            cmd_reg <= 8'h00;
        end else if (cs_fall) begin
            state_reg <= XS_OPCODE;
            bit_cnt_reg <= 3'h0;
            in_cnt_reg <= 2'h0;
        end else if (cs_rise) begin
            state_reg <= XS_IDLE;
        end else if (sck_rise) begin
            shift_reg <= rx_byte;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (byte_done) begin
                case (state_reg)
                    XS_OPCODE: begin
                        cmd_reg <= rx_byte;
                        in_cnt_reg <= 2'h0;
                        if (!op_ok) begin
                            state_reg <= XS_IDLE;
                        end else if (rx_byte == OP_RD_STATUS) begin
                            state_reg <= XS_DATA_OUT;
                        end else if (rx_byte == OP_READ
                                     || rx_byte == OP_WRITE) begin
                            state_reg <= XS_ADDR;
                        end else begin
                            state_reg <= XS_DATA_IN;
                        end
                    end
                    XS_ADDR: begin
                        if (in_cnt_reg == 2'(ADDR_BYTES - 1)) begin
                            in_cnt_reg <= 2'h0;
                            state_reg <= (cmd_reg == OP_READ) ? XS_DATA_OUT
                                                              : XS_DATA_IN;
                        end else begin
                            in_cnt_reg <= in_cnt_reg + 2'h1;
                        end
                    end
                    XS_DATA_IN: begin
                        if (in_cnt_reg != CNT_MAX) begin
                            in_cnt_reg <= in_cnt_reg + 2'h1;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Instruction completion and status

    // Accepted only when select rises on a byte boundary, outside hold
    assign commit = cs_rise && sel_reg && !hold_reg
                    && state_reg == XS_DATA_IN && bit_cnt_reg == 3'h0;
    assign do_wren = commit && cmd_reg == OP_WR_ENABLE && in_cnt_reg == 2'h0;
    assign do_wrdi = commit && cmd_reg == OP_WR_DISABLE && in_cnt_reg == 2'h0;
    assign do_wrsr = commit && cmd_reg == OP_WR_STATUS
                     && in_cnt_reg == 2'h1 && wel_reg;
    assign do_write = commit && cmd_reg == OP_WRITE
                      && u_link.pop_valid && wel_reg;

    always_comb begin
        status_byte = 8'h00;
        status_byte[ST_BUSY] = wip_reg;
        status_byte[ST_WEL] = wel_reg;
        status_byte[ST_BP_LO] = bp_reg[0];
        status_byte[ST_BP_HI] = bp_reg[1];
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            wel_reg <= 1'b0;
            wip_reg <= 1'b0;
            bp_reg <= BP_RST;
        end else begin
            if (do_wren) begin
                wel_reg <= 1'b1;
            end else if (do_wrdi || do_wrsr || do_write) begin
                wel_reg <= 1'b0;
            end
            if (do_wrsr && wp_n_s) begin
                bp_reg <= shift_reg[ST_BP_HI:ST_BP_LO];
            end
            if (do_write) begin
                wip_reg <= 1'b1;
            end else if (wip_reg && !u_link.pop_valid) begin
                wip_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write data buffering and array update

    // Bytes beyond the FIFO depth are refused and never written
    assign u_link.push_valid = byte_done && state_reg == XS_DATA_IN
                               && cmd_reg == OP_WRITE && wel_reg;
    assign u_link.push_data = rx_byte;
    assign u_link.pop_ready = wip_reg;
    // Aborted or partial writes leave nothing behind
    assign u_link.flush = cs_rise && !do_write && !wip_reg;

    byte_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_clk(i_clk_sys),
        .i_rst(i_rst),
        .link(u_link.fifo)
    );

    always_ff @(posedge i_clk_sys) begin
        if (wip_reg && u_link.pop_valid
            && !is_protected(addr_reg[AW-1:0], bp_reg)) begin
            mem[addr_reg[AW-1:0]] <= u_link.pop_data;
        end
    end

    assign first_addr = {addr_reg[7:0], rx_byte};
    assign next_addr = addr_reg + 16'h0001;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            addr_reg <= 16'h0000;
        end else if (byte_done && state_reg == XS_ADDR) begin
            addr_reg <= first_addr;
        end else if (wip_reg && u_link.pop_valid) begin
            // Stays inside its page
            addr_reg[PAGE_BITS-1:0] <= addr_reg[PAGE_BITS-1:0] + 1'b1;
        end else if (sck_fall && state_reg == XS_DATA_OUT
                     && out_cnt_reg == BIT_LAST && cmd_reg == OP_READ) begin
            addr_reg <= next_addr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output shifter and pin drive

    assign load_first = byte_done
        && ((state_reg == XS_OPCODE && op_ok && rx_byte == OP_RD_STATUS)
            || (state_reg == XS_ADDR && cmd_reg == OP_READ
                && in_cnt_reg == 2'(ADDR_BYTES - 1)));

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            out_sh_reg <= 8'h00;
            out_cnt_reg <= 3'h0;
            out_started_reg <= 1'b0;
            q_reg <= 1'b0;
        end else if (cs_fall) begin
            out_started_reg <= 1'b0;
        end else if (load_first) begin
            out_sh_reg <= (state_reg == XS_OPCODE) ? status_byte
                                                   : mem[first_addr[AW-1:0]];
            out_cnt_reg <= 3'h0;
            out_started_reg <= 1'b0;
        end else if (sck_fall && state_reg == XS_DATA_OUT) begin
            q_reg <= out_sh_reg[7];
            out_started_reg <= 1'b1;
            out_cnt_reg <= out_cnt_reg + 3'h1;
            if (out_cnt_reg == BIT_LAST) begin
                out_sh_reg <= (cmd_reg == OP_READ) ? mem[next_addr[AW-1:0]]
                                                   : status_byte;
            end else begin
                out_sh_reg <= {out_sh_reg[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            oe_reg <= 1'b0;
            standby_reg <= 1'b1;
        end else begin
            oe_reg <= sel_reg && !hold_reg && !cs_n_s
                      && state_reg == XS_DATA_OUT && out_started_reg;
            standby_reg <= !sel_reg && !wip_reg;
        end
    end

    assign o_sdo = q_reg;
    assign o_sdo_oe = oe_reg;
    assign o_standby = standby_reg;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);

    property p_rx_msb_first;
        sck_rise |=> shift_reg == {$past(shift_reg[6:0]), $past(sdi_s)};
    endproperty
    a_rx_msb_first: assert property (p_rx_msb_first)
        else $error("input bit not shifted in on clock rise");

    property p_q_on_fall;
        $changed(q_reg) |-> $past(sck_fall);
    endproperty
    a_q_on_fall: assert property (p_q_on_fall)
        else $error("data output changed without a clock fall");

    property p_float_deselected;
        cs_n_s |=> !oe_reg;
    endproperty
    a_float_deselected: assert property (p_float_deselected)
        else $error("output driven while deselected");

    property p_standby;
        (cs_n_s && !wip_reg) [*2] |=> o_standby;
    endproperty
    a_standby: assert property (p_standby)
        else $error("no standby while deselected and idle");

    property p_needs_fall;
        !sel_reg && !cs_fall |=> !sel_reg;
    endproperty
    a_needs_fall: assert property (p_needs_fall)
        else $error("selected without a select falling edge");

    property p_hold_pause;
        hold_reg |=> $stable(bit_cnt_reg) && $stable(shift_reg)
                     && !oe_reg;
    endproperty
    a_hold_pause: assert property (p_hold_pause)
        else $error("transfer advanced or output driven in hold");

    property p_hold_entry;
        sel_reg && !cs_n_s && hold_fall && !sclk_s && !cs_rise |=> hold_reg;
    endproperty
    a_hold_entry: assert property (p_hold_entry)
        else $error("hold not entered on hold fall with clock low");

    property p_hold_abort;
        hold_reg && cs_rise |=> !hold_reg && state_reg == XS_IDLE
                                && !u_link.pop_valid [*2];
    endproperty
    a_hold_abort: assert property (p_hold_abort)
        else $error("deselect in hold did not reset the interface");

    property p_wp_freeze;
        !wp_n_s |=> $stable(bp_reg);
    endproperty
    a_wp_freeze: assert property (p_wp_freeze)
        else $error("block protect changed while write protected");

    property p_bad_op;
        byte_done && state_reg == XS_OPCODE && !valid_op(rx_byte)
            |=> !sel_reg && !oe_reg;
    endproperty
    a_bad_op: assert property (p_bad_op)
        else $error("unknown opcode did not deselect");

    property p_restart;
        cs_fall |=> bit_cnt_reg == 3'h0 && state_reg == XS_OPCODE;
    endproperty
    a_restart: assert property (p_restart)
        else $error("select fall did not restart bit counter");

    property p_first_out;
        load_first ##1 (!sck_fall && !cs_n_s) [*3] ##1 sck_fall
            |=> out_started_reg && q_reg == $past(out_sh_reg[7]);
    endproperty
    a_first_out: assert property (p_first_out)
        else $error("first output bit not on first clock fall");

    c_read: cover property (load_first && cmd_reg == OP_READ);
    c_write: cover property (do_write ##[1:20] !wip_reg);
    c_hold: cover property (hold_reg ##[1:100] !hold_reg && sel_reg);
    c_bad_op: cover property (byte_done && state_reg == XS_OPCODE && !op_ok);
endmodule : eeprom_spi_slave_frontend

/* eeprom_spi_slave_frontend_tb.sv */
// Self-checking bench for the SPI EEPROM serial front end
module eeprom_spi_slave_frontend_tb import eeprom_spi_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic sclk, sdi, cs_n, hold_n, wp_n, sdo, sdo_oe, standby;
    logic flip = 1'b0;
    logic sdo_line;
    int miscompares = 0;
    int compares = 0;
    int seed = 90;
    logic [7:0] exp_q[$];
    logic [7:0] shadow [0:2047];
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    // Released line must not look like held data
    always @(posedge clk_sys) flip <= ~flip;
    assign sdo_line = sdo_oe ? sdo : flip;
    eeprom_spi_slave_frontend #(.MEM_DEPTH(2048), .FIFO_DEPTH(8)) DUT (
        .i_clk_sys(clk_sys), .i_rst(rst), .i_sclk(sclk), .i_sdi(sdi),
        .i_cs_n(cs_n), .i_hold_n(hold_n), .i_wp_n(wp_n), .o_sdo(sdo),
        .o_sdo_oe(sdo_oe), .o_standby(standby));
    spi_master_model mdl (.i_clk(clk_sys), .i_sdo_line(sdo_line),
        .o_sclk(sclk), .o_sdi(sdi), .o_cs_n(cs_n), .o_hold_n(hold_n),
        .o_wp_n(wp_n));
    ////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish();
        if (miscompares == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    task automatic cmd(input logic [7:0] op, input logic [15:0] a,
                       input bit na);
        mdl.select();
        mdl.xfer(op, 1'b0);
        if (na) begin
            mdl.xfer(a[15:8], 1'b0);
            mdl.xfer(a[7:0], 1'b0);
        end
    endtask : cmd
    task automatic rd_status(input logic [7:0] exp);
        cmd(OP_RD_STATUS, 16'h0000, 1'b0);
        exp_q.push_back(exp);
        mdl.xfer(8'h00, 1'b1);
        mdl.deselect();
    endtask : rd_status
    task automatic wr_status(input logic [7:0] v);
        cmd(OP_WR_ENABLE, 16'h0000, 1'b0);
        mdl.deselect();
        cmd(OP_WR_STATUS, 16'h0000, 1'b0);
        mdl.xfer(v, 1'b0);
        mdl.deselect();
    endtask : wr_status
    task automatic write_mem(input logic [15:0] a, input int n, input bit p);
        logic [7:0] d;
        cmd(OP_WR_ENABLE, 16'h0000, 1'b0);
        mdl.deselect();
        cmd(OP_WRITE, a, 1'b1);
        for (int k = 0; k < n; k++) begin
            d = 8'($random(seed));
            if (!p) shadow[11'(a + k)] = d;
            mdl.xfer(d, 1'b0);
        end
        mdl.deselect();
    endtask : write_mem
    task automatic read_mem(input logic [15:0] a, input int n);
        cmd(OP_READ, a, 1'b1);
        for (int k = 0; k < n; k++) begin
            exp_q.push_back(shadow[11'(a + k)]);
            mdl.xfer(8'($random(seed)), 1'b1);
        end
        mdl.deselect();
    endtask : read_mem
    ////////////////////
    always @(mdl.rx_ev) check(mdl.rx_byte, exp_q.pop_front());
    always @(mdl.hold_ev) begin
        check(8'(sdo_oe), 8'h00);
        check(8'(standby), 8'h00);
    end
    initial begin
        #1ms;
        miscompares++;
        tally_and_finish();
    end
    initial begin
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys) rst = 1'b0;
        mdl.tick(6);
        mdl.xfer(OP_RD_STATUS, 1'b0);
        mdl.xfer(8'h00, 1'b0);
        check(8'(sdo_oe), 8'h00);
        mdl.deselect();
        check(8'(standby), 8'h01);
        check(8'(sdo_oe), 8'h00);
        cmd(OP_WR_ENABLE, 16'h0000, 1'b0);
        check(8'(standby), 8'h00);
        mdl.deselect();
        rd_status(8'h02);
        write_mem(16'h07FE, 2, 1'b0);
        write_mem(16'h0000, 1, 1'b0);
        mdl.hold_at = 3;
        write_mem(16'h0010, 8, 1'b0);
        mdl.hold_at = -1;
        // Protect pin only moves between frames
        mdl.set_wp(1'b0);
        wr_status(8'h0C);
        rd_status(8'h00);
        mdl.set_wp(1'b1);
        wr_status(8'h04);
        rd_status(8'h04);
        write_mem(16'h07FE, 2, 1'b1);
        mdl.cpol = 1'b1;
        read_mem(16'h07FE, 3);
        read_mem(16'h0010, 8);
        mdl.cpol = 1'b0;
        cmd(8'hFF, 16'h0000, 1'b0);
        mdl.xfer(8'h00, 1'b0);
        check(8'(sdo_oe), 8'h00);
        mdl.deselect();
        mdl.xfer(8'hA5, 1'b0);
        read_mem(16'h0000, 1);
        cmd(OP_WR_ENABLE, 16'h0000, 1'b0);
        mdl.deselect();
        cmd(OP_WRITE, 16'h0020, 1'b1);
        mdl.xfer(8'h55, 1'b0);
        mdl.abort_in_hold();
        rd_status(8'h06);
        cmd(OP_WR_ENABLE, 16'h0000, 1'b0);
        mdl.deselect();
        cmd(OP_WR_DISABLE, 16'h0000, 1'b0);
        mdl.deselect();
        rd_status(8'h04);
        tally_and_finish();
    end
endmodule : eeprom_spi_slave_frontend_tb

/* fifo_link_if.sv */
// Valid/ready link between the byte engine and its write FIFO
interface fifo_link_if #(parameter int WIDTH = 8);
    logic push_valid;
    logic push_ready;
    logic [WIDTH-1:0] push_data;
    logic pop_valid;
    logic pop_ready;
    logic [WIDTH-1:0] pop_data;
    logic flush;
    modport fifo (input push_valid, push_data, pop_ready, flush,
                  output push_ready, pop_valid, pop_data);
    modport user (output push_valid, push_data, pop_ready, flush,
                  input push_ready, pop_valid, pop_data);
endinterface : fifo_link_if

/* spi_master_model.sv */
// SPI bus master model driving the EEPROM pins
module spi_master_model (
    input wire logic i_clk,
    input wire logic i_sdo_line,
    output logic o_sclk,
    output logic o_sdi,
    output logic o_cs_n,
    output logic o_hold_n,
    output logic o_wp_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic cpol = 1'b0;
    int hold_at = -1;
    logic [7:0] rx_byte;
    event rx_ev;
    event hold_ev;
    // Select low from power-up: no falling edge seen yet
    initial begin
        o_sclk = 1'b0;
        o_sdi = 1'b0;
        o_cs_n = 1'b0;
        o_hold_n = 1'b1;
        o_wp_n = 1'b1;
    end
    ////////////////////
    task automatic tick(input int n);
        repeat (n) @(negedge i_clk);
    endtask : tick
    task automatic select();
        tick(1);
        o_sclk = cpol;
        tick(4);
        o_cs_n = 1'b0;
        tick(4);
    endtask : select
    task automatic deselect();
        tick(4);
        o_sclk = cpol;
        tick(4);
        o_cs_n = 1'b1;
        tick(20);
    endtask : deselect
    // Clock parked low on both hold edges
    task automatic pause();
        tick(4);
        o_hold_n = 1'b0;
        tick(4);
        ->hold_ev;
        repeat (2) begin
            o_sclk = ~o_sclk;
            o_sdi = ~o_sdi;
            tick(4);
        end
        o_hold_n = 1'b1;
        tick(4);
    endtask : pause
    // Deselect while paused: the frame is dropped, not completed
    task automatic abort_in_hold();
        o_sclk = 1'b0;
        tick(4);
        o_hold_n = 1'b0;
        tick(4);
        o_cs_n = 1'b1;
        tick(8);
        o_hold_n = 1'b1;
        tick(20);
    endtask : abort_in_hold
    task automatic set_wp(input logic v);
        tick(1);
        o_wp_n = v;
    endtask : set_wp
    task automatic xfer(input logic [7:0] tx, input bit rd);
        for (int i = 7; i >= 0; i--) begin
            o_sclk = 1'b0;
            if (i == hold_at) pause();
            o_sdi = tx[i];
            tick(4);
            o_sclk = 1'b1;
            rx_byte[i] = i_sdo_line;
            tick(4);
        end
        if (rd) ->rx_ev;
    endtask : xfer
endmodule : spi_master_model
